// ===== pkg/pioc_pkg.sv
package pioc_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int NPORT = 3;
  localparam int PW    = 8;
  localparam int NPIN  = NPORT * PW;
  localparam int NSIG  = 8;

  // ------------------------------------------------------------
  // Register map (byte addresses, low byte of each word)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_DATA     = 8'h00;
  localparam logic [7:0] OFS_SKIP     = 8'h04;
  localparam logic [7:0] OFS_MDIN     = 8'h08;
  localparam logic [7:0] OFS_MDOUT    = 8'h0C;
  localparam logic [7:0] OFS_DRV      = 8'h10;
  localparam logic [7:0] OFS_MASK     = 8'h1F;
  localparam logic [7:0] OFS_RMW      = 8'h60;
  localparam logic [7:0] OFS_BIT_BASE = 8'h80;

  // Field positions of the modify word
  localparam int RMW_OP_LSB   = 8;
  localparam int RMW_PORT_LSB = 12;
  localparam int RMW_BIT_LSB  = 16;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [PW-1:0] RST_LATCH = 8'hFF;
  localparam logic [PW-1:0] RST_SKIP  = 8'h00;
  localparam logic [PW-1:0] RST_MDIN  = 8'hFF;
  localparam logic [PW-1:0] RST_MDOUT = 8'h00;
  localparam logic [PW-1:0] RST_DRV   = 8'h00;

  // Fixed pins and signals
  localparam logic [4:0] DIG_ONLY_PIN = 5'h17;
  localparam logic [2:0] SIG_SDA      = 3'h0;
  localparam logic [2:0] SIG_SCL      = 3'h1;

  typedef enum logic [2:0] {
    OP_AND   = 3'h0,
    OP_OR    = 3'h1,
    OP_XOR   = 3'h2,
    OP_CPL   = 3'h3,
    OP_INC   = 3'h4,
    OP_DEC   = 3'h5,
    OP_BITWR = 3'h6,
    OP_JBC   = 3'h7
  } pioc_rmw_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } pioc_bus_state_type;

endpackage

// ===== pkg/pioc_xbar_if.sv
interface pioc_xbar_if import pioc_pkg::*; ;
  logic [NPIN-1:0]      skip;
  logic [NSIG-1:0]      sig_en;
  logic [NPIN-1:0]      assigned;
  logic [NPIN-1:0][2:0] sig_idx;

  modport ctrl (output skip, output sig_en,
                input assigned, input sig_idx);
  modport xbar (input skip, input sig_en,
                output assigned, output sig_idx);
endinterface

// ===== rtl/pioc_sync.sv
module pioc_sync import pioc_pkg::*; (
  input  wire logic            i_mclk,
  input  wire logic            i_rst_n,
  input  wire logic            i_ce,
  input  wire logic [NPIN-1:0] i_async,
  output logic      [NPIN-1:0] o_level
);
  logic [NPIN-1:0] s1;
  logic [NPIN-1:0] s2;
  logic [NPIN-1:0] s3;
  logic [NPIN-1:0] lvl;
  logic [NPIN-1:0] next_lvl;

  // ----------------------------------------------------------
  // Accept a change only once stages two and three agree
  // ----------------------------------------------------------
  always_comb begin
    next_lvl = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & lvl);
  end

  // s1 feeds s2 only; it may be metastable
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      // Idle level of a pulled-up line: no false low after reset
      s1  <= '1;
      s2  <= '1;
      s3  <= '1;
      lvl <= '1;
    end else if (i_ce) begin
      s1  <= i_async;
      s2  <= s1;
      s3  <= s2;
      lvl <= next_lvl;
    end
  end

  assign o_level = lvl;
endmodule

// ===== rtl/pioc_xbar.sv
module pioc_xbar import pioc_pkg::*; (
  pioc_xbar_if.xbar x
);
  // First enabled signal at or above index from; NSIG if none
  function automatic logic [3:0] next_en(input logic [NSIG-1:0] en,
                                         input logic [3:0] from);
    logic [3:0] r;
    r = 4'(NSIG);
    for (int i = NSIG - 1; i >= 0; i--) begin
      if (en[i] && (4'(i) >= from)) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------
  // Priority walk over pins, skipped pins passed over
  // ----------------------------------------------------------
  always_comb begin
    logic [3:0] nxt;
    logic [3:0] sel;
    nxt = 4'h0;
    sel = 4'h0;
    x.assigned = '0;
    x.sig_idx  = '0;
    for (int p = 0; p < NPIN; p++) begin
      if (!x.skip[p]) begin
        sel = next_en(x.sig_en, nxt);
        if (sel < 4'(NSIG)) begin
          x.assigned[p] = 1'b1;
          x.sig_idx[p]  = sel[2:0];
          nxt           = sel + 4'h1;
        end
      end
    end
  end
endmodule

// ===== rtl/pioc_top.sv
// Notes on behaviour
// - A write to a port data register lands in its latch, which holds.
// - A plain read of a port data register returns the pin levels.
// - Modify operations read the latch, change it and write it back.
// - Each port is reachable as a whole byte and as single bits.
// - A per-pin skip mask makes the crossbar pass over that pin.
// - Each pin except the digital-only pin is set analog or digital by software.
// - The digital-only pin stays digital whatever its input mode bit.
// - Each driver is set open-drain or push-pull by software.
// - Pins carrying SMBus data and clock always drive open-drain.
// - Drive strength is selectable per pin and is low after reset.
module pioc_top import pioc_pkg::*; (
  input  wire logic            i_mclk,
  input  wire logic            i_rst_n,
  input  wire logic            i_ce,
  input  wire logic            i_wb_cyc,
  input  wire logic            i_wb_stb,
  input  wire logic            i_wb_we,
  input  wire logic [7:0]      i_wb_adr,
  input  wire logic [3:0]      i_wb_sel,
  input  wire logic [31:0]     i_wb_dat,
  output logic      [31:0]     o_wb_dat,
  output logic                 o_wb_ack,
  input  wire logic [NPIN-1:0] i_pin_in,
  output logic      [NPIN-1:0] o_pin_out,
  output logic      [NPIN-1:0] o_pin_oe,
  output logic      [NPIN-1:0] o_pin_hd,
  output logic      [NPIN-1:0] o_pin_analog,
  input  wire logic [NSIG-1:0] i_sig_en,
  input  wire logic [NSIG-1:0] i_sig_out,
  input  wire logic [NSIG-1:0] i_sig_oe,
  output logic      [NSIG-1:0] o_sig_in
);

  // ----------------------------------------------------------
  // Storage
  // ----------------------------------------------------------
  logic [NPORT-1:0][PW-1:0] latch, next_latch;
  logic [NPORT-1:0][PW-1:0] skip, next_skip;
  logic [NPORT-1:0][PW-1:0] mdin, next_mdin;
  logic [NPORT-1:0][PW-1:0] mdout, next_mdout;
  logic [NPORT-1:0][PW-1:0] drv, next_drv;
  logic [8:0]               rmw_res, next_rmw_res;
  pioc_bus_state_type       state, next_state;
  logic                     next_ack;
  logic [31:0]              next_rdat;
  logic [NPIN-1:0]          next_pin_out, next_pin_oe;
  logic [NPIN-1:0]          next_pin_hd, next_pin_analog;
  logic [NSIG-1:0]          next_sig_in;
  logic [NPIN-1:0]          lvl;
  logic [NPIN-1:0]          latch_f, skip_f, mdin_f, mdout_f, drv_f;
  logic [NPIN-1:0]          smb_hi;

  // Pin number from port and bit
  function automatic logic [4:0] pin_of(input logic [1:0] port,
                                        input logic [2:0] b);
    return {port, b};
  endfunction

  // Port index is legal
  function automatic logic port_ok(input logic [1:0] port);
    return 32'(port) < NPORT;
  endfunction

  // Modify step on a latch byte; bit 8 is the test/jump flag
  function automatic logic [8:0] rmw_calc(input logic [PW-1:0] v,
                                          input pioc_rmw_op_type op,
                                          input logic [PW-1:0] opnd,
                                          input logic [2:0] b);
    logic [PW-1:0] r;
    logic          f;
    r = v;
    f = 1'b0;
    case (op)
      OP_AND:   r = v & opnd;
      OP_OR:    r = v | opnd;
      OP_XOR:   r = v ^ opnd;
      OP_CPL:   r[b] = ~v[b];
      OP_INC:   r = v + 8'h01;
      OP_DEC: begin
        r = v - 8'h01;
        f = (r != 8'h00);
      end
      OP_BITWR: r[b] = opnd[0];
      OP_JBC: begin
        f    = v[b];
        r[b] = 1'b0;
      end
      default:  r = v;
    endcase
    return {f, r};
  endfunction

  assign latch_f = latch;
  assign skip_f  = skip;
  assign mdin_f  = mdin;
  assign mdout_f = mdout;
  assign drv_f   = drv;

  // ----------------------------------------------------------
  // Pin input synchroniser and crossbar
  // ----------------------------------------------------------
  pioc_sync u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_async (i_pin_in),
    .o_level (lvl)
  );

  pioc_xbar_if xb ();

  assign xb.skip   = skip_f;
  assign xb.sig_en = i_sig_en;

  pioc_xbar u_xbar (
    .x (xb.xbar)
  );

  // ----------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------
  logic            req, wr;
  logic            in_port, in_rmw, in_bit;
  logic [1:0]      a_port, r_port;
  logic [2:0]      a_bit, r_bit;
  logic [7:0]      a_off;
  pioc_rmw_op_type r_op;
  logic [PW-1:0]   r_opnd;

  // A request is taken once; the ack cycle ignores the bus
  assign req     = i_ce & i_wb_cyc & i_wb_stb & (state == ST_IDLE);
  assign wr      = req & i_wb_we & i_wb_sel[0];
  assign a_port  = i_wb_adr[6:5];
  assign a_bit   = i_wb_adr[4:2];
  assign a_off   = i_wb_adr & OFS_MASK;
  assign in_port = (i_wb_adr < OFS_RMW) & port_ok(a_port);
  assign in_rmw  = (i_wb_adr & ~8'h03) == OFS_RMW;
  assign in_bit  = ((i_wb_adr & OFS_BIT_BASE) != 8'h00) & port_ok(a_port);
  assign r_port  = i_wb_dat[RMW_PORT_LSB +: 2];
  assign r_bit   = i_wb_dat[RMW_BIT_LSB +: 3];
  assign r_op    = pioc_rmw_op_type'(i_wb_dat[RMW_OP_LSB +: 3]);
  assign r_opnd  = i_wb_dat[PW-1:0];

  // ----------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------
  always_comb begin
    next_latch   = latch;
    next_skip    = skip;
    next_mdin    = mdin;
    next_mdout   = mdout;
    next_drv     = drv;
    next_rmw_res = rmw_res;
    if (wr && in_port) begin
      case (a_off)
        OFS_DATA:  next_latch[a_port] = r_opnd;
        OFS_SKIP:  next_skip[a_port]  = r_opnd;
        OFS_MDIN:  next_mdin[a_port]  = r_opnd;
        OFS_MDOUT: next_mdout[a_port] = r_opnd;
        OFS_DRV:   next_drv[a_port]   = r_opnd;
        default:   next_latch = latch;
      endcase
    end else if (wr && in_rmw && port_ok(r_port)) begin
      // Source is the latch, not the pins
      next_rmw_res = rmw_calc(latch[r_port], r_op, r_opnd, r_bit);
      next_latch[r_port] = next_rmw_res[PW-1:0];
    end else if (wr && in_bit) begin
      next_latch[a_port][a_bit] = i_wb_dat[0];
    end
  end

  // Read data; pins for data, registers otherwise, zero if unmapped
  always_comb begin
    next_rdat = o_wb_dat;
    if (req && !i_wb_we) begin
      next_rdat = 32'h0000_0000;
      if (in_port) begin
        case (a_off)
          OFS_DATA:  next_rdat[PW-1:0] = lvl[{a_port, 3'h0} +: PW];
          OFS_SKIP:  next_rdat[PW-1:0] = skip[a_port];
          OFS_MDIN:  next_rdat[PW-1:0] = mdin[a_port];
          OFS_MDOUT: next_rdat[PW-1:0] = mdout[a_port];
          OFS_DRV:   next_rdat[PW-1:0] = drv[a_port];
          default:   next_rdat = 32'h0000_0000;
        endcase
      end else if (in_rmw) begin
        next_rdat[8:0] = rmw_res;
      end else if (in_bit) begin
        next_rdat[0] = lvl[pin_of(a_port, a_bit)];
      end
    end
  end

  // Bus handshake: one-cycle ack; a new request can be taken in the cycle after it
  always_comb begin
    next_ack = req;
    case (state)
      ST_IDLE: next_state = req ? ST_ACK : ST_IDLE;
      ST_ACK:  next_state = i_ce ? ST_IDLE : ST_ACK;
      default: next_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------
  always_comb begin
    logic       dig;
    logic       val;
    logic       oe;
    logic       od;
    logic [2:0] s;
    dig = 1'b0;
    val = 1'b0;
    oe  = 1'b0;
    od  = 1'b0;
    s   = 3'h0;
    next_sig_in = '1;
    smb_hi      = '0;
    for (int p = 0; p < NPIN; p++) begin
      s   = xb.sig_idx[p];
      // Digital-only pin ignores its input mode bit
      dig = mdin_f[p] | (5'(p) == DIG_ONLY_PIN);
      val = xb.assigned[p] ? i_sig_out[s] : latch_f[p];
      oe  = xb.assigned[p] ? i_sig_oe[s] : 1'b1;
      // SMBus pins forced open-drain
      od  = ~mdout_f[p] | (xb.assigned[p] &
            ((s == SIG_SDA) | (s == SIG_SCL)));
      smb_hi[p] = xb.assigned[p] & val &
                  ((s == SIG_SDA) | (s == SIG_SCL));
      next_pin_out[p]    = val;
      next_pin_oe[p]     = dig & oe & (od ? ~val : 1'b1);
      next_pin_hd[p]     = drv_f[p];
      next_pin_analog[p] = ~dig;
      if (xb.assigned[p]) begin
        next_sig_in[s] = lvl[p];
      end
    end
  end

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      latch        <= {NPORT{RST_LATCH}};
      skip         <= {NPORT{RST_SKIP}};
      mdin         <= {NPORT{RST_MDIN}};
      mdout        <= {NPORT{RST_MDOUT}};
      drv          <= {NPORT{RST_DRV}};
      rmw_res      <= 9'h000;
      state        <= ST_IDLE;
      o_wb_ack     <= 1'b0;
      o_wb_dat     <= 32'h0000_0000;
      o_pin_out    <= '0;
      o_pin_oe     <= '0;
      o_pin_hd     <= '0;
      o_pin_analog <= '0;
      o_sig_in     <= '1;
    end else if (i_ce) begin
      latch        <= next_latch;
      skip         <= next_skip;
      mdin         <= next_mdin;
      mdout        <= next_mdout;
      drv          <= next_drv;
      rmw_res      <= next_rmw_res;
      state        <= next_state;
      o_wb_ack     <= next_ack;
      o_wb_dat     <= next_rdat;
      o_pin_out    <= next_pin_out;
      o_pin_oe     <= next_pin_oe;
      o_pin_hd     <= next_pin_hd;
      o_pin_analog <= next_pin_analog;
      o_sig_in     <= next_sig_in;
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  logic [PW-1:0] rmw_or_val;
  logic [PW-1:0] rd_lvl;
  logic [4:0]    bit_pin;
  assign rmw_or_val = latch[r_port] | r_opnd;
  assign bit_pin    = pin_of(a_port, a_bit);
  assign rd_lvl     = lvl[{a_port, 3'h0} +: PW];

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_wr_data;
    wr && in_port && (a_off == OFS_DATA);
  endsequence
  sequence s_rd_data;
    req && !i_wb_we && in_port && (a_off == OFS_DATA);
  endsequence
  sequence s_rmw_or;
    wr && in_rmw && port_ok(r_port) && (r_op == OP_OR);
  endsequence
  sequence s_bit_wr;
    wr && !in_rmw && in_bit;
  endsequence

  AST_WR_LATCH: assert property (s_wr_data |=>
    latch[$past(a_port)] == $past(r_opnd))
    else $error("port write not in latch");
  AST_LATCH_HOLD: assert property ((i_ce && !wr) |=>
    $stable(latch))
    else $error("latch changed without write");
  AST_RD_PIN: assert property (s_rd_data |=>
    o_wb_ack && (o_wb_dat[PW-1:0] == $past(rd_lvl)))
    else $error("port read not from pins");
  AST_RMW_OR: assert property (s_rmw_or |=>
    latch[$past(r_port)] == $past(rmw_or_val))
    else $error("modify not based on latch");
  AST_BIT_WR: assert property (s_bit_wr |=>
    latch_f[$past(bit_pin)] == $past(i_wb_dat[0]))
    else $error("bit write lost");
  AST_SKIP_PASS: assert property (
    (xb.assigned & skip_f) == '0)
    else $error("skipped pin assigned");
  AST_DIG_ONLY: assert property (i_ce |=>
    !o_pin_analog[DIG_ONLY_PIN])
    else $error("digital-only pin went analog");
  AST_SMB_OD: assert property ((i_ce && (smb_hi != '0)) |=>
    (o_pin_oe & $past(smb_hi)) == '0)
    else $error("SMBus pin driven high");
  AST_DRV_RST: assert property (!$past(i_rst_n) |->
    o_pin_hd == '0)
    else $error("drive not low after reset");
  AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");

endmodule

// ===== dv/pioc_board.sv
module pioc_board import pioc_pkg::*; (
  input  wire logic [NPIN-1:0] i_pin_out,
  input  wire logic [NPIN-1:0] i_pin_oe,
  input  wire logic [NPIN-1:0] i_ext_en,
  input  wire logic [NPIN-1:0] i_ext_val,
  output logic      [NPIN-1:0] o_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------
  // Board lines
  // ----------------------------------------------------------

  // Pull-up on every line: a released open-drain pin reads high
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      if (i_pin_oe[p]) begin
        o_pin_in[p] = i_pin_out[p];
      end else if (i_ext_en[p]) begin
        o_pin_in[p] = i_ext_val[p]; // External part pulls the line
      end else begin
        o_pin_in[p] = 1'b1;
      end
    end
  end
endmodule

// ===== dv/testbench.sv
module testbench import pioc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic        we;
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [31:0] exp;
  } pioc_tb_row_type;
  typedef struct packed {
    pioc_rmw_op_type op;
    logic [2:0]      bsel;
    logic [7:0]      opnd;
    logic [8:0]      exp;
  } pioc_tb_mod_type;

  // ----------------------------------------------------------
  // Stimulus tables
  // ----------------------------------------------------------
  localparam pioc_tb_row_type ROWS [20] = '{
    '{1'b0, 8'h04, 32'h0, 32'h00}, '{1'b0, 8'h28, 32'h0, 32'hFF},
    '{1'b0, 8'h4C, 32'h0, 32'h00}, '{1'b0, 8'h10, 32'h0, 32'h00},
    '{1'b0, 8'h00, 32'h0, 32'hFF}, '{1'b1, 8'h0C, 32'hFF, 32'h0},
    '{1'b1, 8'h00, 32'hA5, 32'h0}, '{1'b0, 8'h00, 32'h0, 32'hA5},
    '{1'b1, 8'h80, 32'h0, 32'h0},  '{1'b0, 8'h00, 32'h0, 32'hA4},
    '{1'b0, 8'h84, 32'h0, 32'h0},  '{1'b0, 8'h88, 32'h0, 32'h1},
    '{1'b1, 8'h30, 32'hFF, 32'h0}, '{1'b0, 8'h30, 32'h0, 32'hFF},
    '{1'b1, 8'h48, 32'h0, 32'h0},  '{1'b0, 8'h48, 32'h0, 32'h0},
    '{1'b1, 8'h74, 32'h55, 32'h0}, '{1'b0, 8'h74, 32'h0, 32'h0},
    '{1'b1, 8'h24, 32'h0F, 32'h0}, '{1'b0, 8'h24, 32'h0, 32'h0F}};
  // Latch starts at 3C; each step works on the previous result
  localparam pioc_tb_mod_type MODS [8] = '{
    '{OP_AND, 3'h0, 8'h0F, 9'h00C}, '{OP_OR, 3'h0, 8'h81, 9'h08D},
    '{OP_XOR, 3'h0, 8'hFF, 9'h072}, '{OP_CPL, 3'h0, 8'h00, 9'h073},
    '{OP_INC, 3'h0, 8'h00, 9'h074}, '{OP_DEC, 3'h0, 8'h00, 9'h173},
    '{OP_BITWR, 3'h7, 8'h01, 9'h0F3}, '{OP_JBC, 3'h4, 8'h00, 9'h1E3}};

  logic            i_mclk = 1'b0;
  logic            rst_n  = 1'b0;
  logic            ce     = 1'b1;
  logic            cyc    = 1'b0;
  logic            stb    = 1'b0;
  logic            wen    = 1'b0;
  logic [7:0]      adr    = 8'h00;
  logic [3:0]      sel    = 4'h0;
  logic [31:0]     wdat   = 32'h0;
  logic [3:0]      wsel   = 4'hF;
  logic [31:0]     rdat;
  logic [31:0]     q;
  logic            ack;
  logic [NPIN-1:0] pout, poe, phd, pana, pin;
  logic [NPIN-1:0] ext_en  = '0;
  logic [NPIN-1:0] ext_val = '0;
  logic [NSIG-1:0] sen  = '0;
  logic [NSIG-1:0] sout = '0;
  logic [NSIG-1:0] soe  = '0;
  logic [NSIG-1:0] sin;
  int              miscompares = 0;
  int              comparisons = 0;

  // 100 MHz clock
  always #5 i_mclk = ~i_mclk;

  pioc_top dut_u (.i_mclk(i_mclk), .i_rst_n(rst_n), .i_ce(ce),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(wen), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_pin_in(pin), .o_pin_out(pout), .o_pin_oe(poe), .o_pin_hd(phd),
    .o_pin_analog(pana), .i_sig_en(sen), .i_sig_out(sout),
    .i_sig_oe(soe), .o_sig_in(sin));

  pioc_board board_u (.i_pin_out(pout), .i_pin_oe(poe),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin_in(pin));

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle; the trailing idle lets pins pass the synchroniser
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge i_mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    wen  <= w;
    adr  <= a;
    wdat <= d;
    sel  <= wsel;
    // Ack is sampled at the rising edge; only the watchdog ends a hang
    do begin
      @(posedge i_mclk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    wen <= 1'b0;
    repeat (8) @(posedge i_mclk);
  endtask

  task automatic final_report();
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #100us;
    miscompares++;
    final_report();
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
    chk("drive after reset", 32'(phd), 32'h0);
    chk("analog after reset", 32'(pana), 32'h0);
    chk("open drain enables", 32'(poe), 32'h0);
    foreach (ROWS[i]) begin
      wb(ROWS[i].we, ROWS[i].adr, ROWS[i].dat);
      if (!ROWS[i].we) begin
        chk("register read", q, ROWS[i].exp);
      end
    end
    chk("port0 out", 32'(pout[7:0]), 32'hA4);
    chk("port0 push-pull oe", 32'(poe[7:0]), 32'hFF);
    chk("drive select", 32'(phd), 32'h00FF00);
    chk("analog select", 32'(pana), 32'h7F0000);
    // Pull pin 10 low while its latch bit is high
    wb(1'b1, 8'h20, 32'h3C);
    ext_en <= 24'h000400;
    repeat (8) @(posedge i_mclk);
    chk("port1 open-drain oe", 32'(poe[15:8]), 32'hC3);
    wb(1'b0, 8'h20, 32'h0);
    chk("port1 pins", q, 32'h38);
    foreach (MODS[i]) begin
      wb(1'b1, OFS_RMW, {13'h0, MODS[i].bsel, 4'h1, 1'b0, MODS[i].op,
                         MODS[i].opnd});
      wb(1'b0, OFS_RMW, 32'h0);
      chk("modify", q, 32'(MODS[i].exp));
    end
    chk("port1 out", 32'(pout[15:8]), 32'hE3);
    // Skip pin 0; signals 0..2 should land on pins 1..3
    wb(1'b1, 8'h04, 32'h01);
    sen    <= 8'h07;
    sout   <= 8'h05;
    soe    <= 8'h07;
    ext_en <= 24'h000002;
    repeat (8) @(posedge i_mclk);
    chk("crossbar oe", 32'(poe[3:0]), 32'hD);
    chk("crossbar out", 32'(pout[3:0]), 32'hA);
    chk("signal in", 32'(sin), 32'hFC);
    wb(1'b0, 8'h00, 32'h0);
    chk("pins under crossbar", q, 32'hA8);
    // Clock enable low freezes the synchronised signal inputs
    ce     <= 1'b0;
    ext_en <= 24'h000000;
    repeat (8) @(posedge i_mclk);
    chk("frozen signal in", 32'(sin), 32'hFC);
    ce <= 1'b1;
    repeat (8) @(posedge i_mclk);
    chk("signal in resumed", 32'(sin), 32'hFD);
    // Second reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
    chk("drive after reset", 32'(phd), 32'h0);
    wb(1'b0, 8'h0C, 32'h0);
    chk("output mode after reset", q, 32'h0);
    wb(1'b0, 8'h48, 32'h0);
    chk("input mode after reset", q, 32'hFF);
    // A write without byte lane 0 is acknowledged but lost
    wsel = 4'hE;
    wb(1'b1, 8'h10, 32'hFF);
    wsel = 4'hF;
    wb(1'b0, 8'h10, 32'h0);
    chk("write without lane 0", q, 32'h0);
    final_report();
  end
endmodule
